// *** logic/twe_device.sv ***
// module: device end, condition detection, word framing and acknowledge
`timescale 1ns/1ps
module twe_device #(
    parameter int WRITE_CYCLES = twe_pkg::WRITE_CYCLE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // link
    twe_link_if.device link,
    // straps
    input wire logic [2:0] hw_address_straps,
    // user side: read data source and received word sink
    input wire logic [7:0] tx_data,
    output logic tx_take,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_is_addr,
    output logic standby
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] strap_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            strap_sync_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
            // strap bit 2, the only strap used, is a pin too, so it crosses in like the link wires
            strap_sync_reg <= {strap_sync_reg[0], hw_address_straps[2]};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    // a data edge seen with the clock steadily high is a condition, never data
    wire cond_ok = scl_s & scl_d_reg;
    wire start_det = cond_ok & sda_d_reg & ~sda_s;
    wire stop_det = cond_ok & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------
    // framing state
    // ------------------------------------------------------------
    twe_pkg::twe_dev_state_t state_reg;
    twe_pkg::twe_dev_state_t state_next;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic first_reg;
    logic read_reg;
    logic wrote_reg;
    logic acked_reg;
    logic sda_oe_n_reg;
    logic [31:0] wr_cnt_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg;
    logic rx_is_addr_reg;
    logic tx_take_reg;
    logic standby_reg;

    wire [7:0] word_in = {shift_reg[6:0], sda_s};
    wire addr_match = word_in[7:4] == twe_pkg::DEV_TYPE_CODE
        && word_in[3] == strap_sync_reg[1];
    wire word_done = scl_rise && bit_reg == twe_pkg::BIT_LAST;
    wire busy_done = wr_cnt_reg == 32'h0;
    // the master ack is sampled on the ninth rise, so a sent word ends on the fall after it
    wire ack_over = scl_fall && bit_reg == twe_pkg::BIT_ACK + 4'h1;
    // master ack is low data on the ninth clock of a read word
    wire mst_ack = scl_rise && bit_reg == twe_pkg::BIT_ACK && !sda_s;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            twe_pkg::TWE_STANDBY: begin
                if (start_det) begin
                    state_next = twe_pkg::TWE_RECV;
                end
            end
            twe_pkg::TWE_RECV: begin
                if (stop_det) begin
                    state_next = wrote_reg ? twe_pkg::TWE_BUSYWR : twe_pkg::TWE_STANDBY;
                end else if (scl_fall && bit_reg == twe_pkg::BIT_ACK) begin
                    state_next = acked_reg ? twe_pkg::TWE_ACK : twe_pkg::TWE_STANDBY;
                end
            end
            twe_pkg::TWE_ACK: begin
                if (stop_det) begin
                    state_next = wrote_reg ? twe_pkg::TWE_BUSYWR : twe_pkg::TWE_STANDBY;
                end else if (scl_fall) begin
                    state_next = read_reg ? twe_pkg::TWE_SEND : twe_pkg::TWE_RECV;
                end
            end
            twe_pkg::TWE_SEND: begin
                if (stop_det) begin
                    state_next = twe_pkg::TWE_STANDBY;
                end else if (ack_over) begin
                    state_next = acked_reg ? twe_pkg::TWE_SEND : twe_pkg::TWE_STANDBY;
                end
            end
            twe_pkg::TWE_BUSYWR: begin
                if (busy_done) begin
                    state_next = twe_pkg::TWE_STANDBY;
                end
            end
            default: state_next = twe_pkg::TWE_STANDBY;
        endcase
        // a start anywhere but during the internal write reopens the address word
        if (start_det && state_reg != twe_pkg::TWE_BUSYWR) begin
            state_next = twe_pkg::TWE_RECV;
        end
    end

    wire new_frame = start_det && state_reg != twe_pkg::TWE_BUSYWR;
    wire in_recv = state_reg == twe_pkg::TWE_RECV;
    wire in_send = state_reg == twe_pkg::TWE_SEND;
    wire ack_slot = in_recv && scl_fall && bit_reg == twe_pkg::BIT_LAST + 4'h1;
    wire load_tx = state_reg == twe_pkg::TWE_ACK && scl_fall && read_reg
        || in_send && ack_over && acked_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= twe_pkg::TWE_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit counter, shifter and frame flags
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_reg <= 1'b1;
            read_reg <= 1'b0;
            wrote_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else if (new_frame) begin
            bit_reg <= 4'h0;
            first_reg <= 1'b1;
            // an abandoned frame must not start a write cycle, so recovery ends idle
            wrote_reg <= 1'b0;
            read_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else if (state_reg == twe_pkg::TWE_BUSYWR || state_reg == twe_pkg::TWE_STANDBY) begin
            bit_reg <= 4'h0;
            wrote_reg <= 1'b0;
        end else if (load_tx) begin
            bit_reg <= 4'h0;
            shift_reg <= tx_data;
        end else if (state_reg == twe_pkg::TWE_ACK && scl_fall) begin
            bit_reg <= 4'h0;
        end else if (in_send && scl_fall && bit_reg != twe_pkg::BIT_ACK) begin
            shift_reg <= {shift_reg[6:0], 1'b1};
        end else if (scl_rise) begin
            if (in_recv && bit_reg <= twe_pkg::BIT_LAST) begin
                shift_reg <= word_in;
            end
            if (word_done && in_recv) begin
                acked_reg <= first_reg ? addr_match : 1'b1;
                read_reg <= first_reg ? word_in[0] : read_reg;
                wrote_reg <= wrote_reg | (!first_reg && !read_reg);
                first_reg <= 1'b0;
            end
            if (in_send && bit_reg == twe_pkg::BIT_ACK) begin
                acked_reg <= mst_ack;
            end
            bit_reg <= bit_reg + 4'h1;
        end else if (ack_slot) begin
            bit_reg <= twe_pkg::BIT_ACK;
        end
    end

    // self-timed write cycle counter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_cnt_reg <= 32'h0;
        end else if (state_next == twe_pkg::TWE_BUSYWR && state_reg != twe_pkg::TWE_BUSYWR) begin
            wr_cnt_reg <= 32'(WRITE_CYCLES);
        end else if (wr_cnt_reg != 32'h0) begin
            wr_cnt_reg <= wr_cnt_reg - 32'h1;
        end
    end

    // ------------------------------------------------------------
    // open-drain data drive and user outputs
    // ------------------------------------------------------------
    // drive changes only on scl fall so the master never sees a false condition
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sda_oe_n_reg <= 1'b1;
        end else if (new_frame || stop_det || state_next == twe_pkg::TWE_STANDBY) begin
            sda_oe_n_reg <= 1'b1;
        end else if (ack_slot) begin
            sda_oe_n_reg <= !acked_reg;
        end else if (load_tx) begin
            sda_oe_n_reg <= tx_data[7];
        end else if (in_send && scl_fall) begin
            sda_oe_n_reg <= bit_reg == twe_pkg::BIT_ACK ? 1'b1 : shift_reg[6];
        end else if (state_reg == twe_pkg::TWE_ACK && scl_fall) begin
            sda_oe_n_reg <= 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_data_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            rx_is_addr_reg <= 1'b0;
            tx_take_reg <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            rx_valid_reg <= word_done && in_recv && (!first_reg || addr_match);
            rx_data_reg <= word_done && in_recv ? word_in : rx_data_reg;
            rx_is_addr_reg <= word_done && in_recv ? first_reg : rx_is_addr_reg;
            tx_take_reg <= load_tx;
            standby_reg <= state_next == twe_pkg::TWE_STANDBY;
        end
    end

    assign link.sda_d_out = 1'b0;
    assign link.sda_d_oe_n = sda_oe_n_reg;
    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign rx_is_addr = rx_is_addr_reg;
    assign tx_take = tx_take_reg;
    assign standby = standby_reg;
endmodule

// *** logic/twe_pkg.sv ***
// package: shared constants and types of the two-wire memory bus front end
package twe_pkg;
    // ------------------------------------------------------------
    // word framing
    // ------------------------------------------------------------
    localparam int WORD_BITS = 8;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam logic [3:0] RECOVERY_CLOCKS = 4'h9;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SCL_HALF_NS = 2000;
    localparam int SCL_HALF_CYCLES = SCL_HALF_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SCL_HALF_CNT = 8'(SCL_HALF_CYCLES - 1);
    // ------------------------------------------------------------
    // device states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        TWE_STANDBY = 5'h01,
        TWE_RECV = 5'h02,
        TWE_ACK = 5'h04,
        TWE_SEND = 5'h08,
        TWE_BUSYWR = 5'h10
    } twe_dev_state_t;
    // ------------------------------------------------------------
    // master states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        TWE_M_IDLE = 7'h01,
        TWE_M_START = 7'h02,
        TWE_M_BIT = 7'h04,
        TWE_M_STOP = 7'h08,
        TWE_M_RCLK = 7'h10,
        TWE_M_RSTART = 7'h20,
        TWE_M_RSTOP = 7'h40
    } twe_mst_state_t;
endpackage

// *** logic/twe_link_if.sv ***
// interface: open-drain clock and data wires between master and device
`timescale 1ns/1ps
interface twe_link_if;
    logic scl_out;
    logic scl_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_d_out;
    logic sda_d_oe_n;
    logic scl;
    logic sda;
    // wired-and with pull-up: a driver pulls low only when enabled
    assign scl = scl_oe_n | scl_out;
    assign sda = (sda_m_oe_n | sda_m_out) & (sda_d_oe_n | sda_d_out);
    modport master (output scl_out, output scl_oe_n, output sda_m_out, output sda_m_oe_n,
        input scl, input sda);
    modport device (output sda_d_out, output sda_d_oe_n, input scl, input sda);
endinterface

// *** logic/twe_master.sv ***
// module: master end, issues frames, bytes and the recovery sequence
`timescale 1ns/1ps
module twe_master (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // link
    twe_link_if.master link,
    // user command port
    input wire logic cmd_start,
    input wire logic cmd_byte,
    input wire logic cmd_stop,
    input wire logic cmd_recover,
    input wire logic cmd_read,
    input wire logic cmd_ack,
    input wire logic [7:0] cmd_data,
    output logic busy,
    output logic done,
    output logic [7:0] rd_data,
    output logic ack_seen
);
    // ------------------------------------------------------------
    // scl divider tick
    // ------------------------------------------------------------
    logic [7:0] div_reg;
    wire tick = div_reg == 8'h00;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= twe_pkg::SCL_HALF_CNT;
        end else begin
            div_reg <= tick ? twe_pkg::SCL_HALF_CNT : div_reg - 8'h01;
        end
    end
    // sda input crosses in from the wire
    logic [1:0] sda_sync_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sda_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
        end
    end

    // ------------------------------------------------------------
    // sequencer; phase 0..3 per bit: low, low-set, high, high-sample
    // ------------------------------------------------------------
    twe_pkg::twe_mst_state_t state_reg;
    logic [1:0] ph_reg;
    logic [3:0] cnt_reg;
    logic [8:0] sh_reg;
    logic scl_reg;
    logic sda_reg;
    logic done_reg;
    logic [7:0] rd_data_reg;
    logic ack_reg;
    wire idle = state_reg == twe_pkg::TWE_M_IDLE;
    wire last_ph = tick && ph_reg == 2'h3;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= twe_pkg::TWE_M_IDLE;
            ph_reg <= 2'h0;
            cnt_reg <= 4'h0;
            sh_reg <= 9'h1FF;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            done_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (idle) begin
                ph_reg <= 2'h0;
                cnt_reg <= 4'h0;
                // read words send ones and the chosen ack in the ninth slot
                sh_reg <= cmd_read ? {8'hFF, !cmd_ack} : {cmd_data, 1'b1};
                if (cmd_start) begin
                    state_reg <= twe_pkg::TWE_M_START;
                end else if (cmd_byte) begin
                    state_reg <= twe_pkg::TWE_M_BIT;
                end else if (cmd_stop) begin
                    state_reg <= twe_pkg::TWE_M_STOP;
                end else if (cmd_recover) begin
                    state_reg <= twe_pkg::TWE_M_RCLK;
                end
            end else if (tick) begin
                ph_reg <= ph_reg + 2'h1;
                case (state_reg)
                    twe_pkg::TWE_M_START, twe_pkg::TWE_M_RSTART: begin
                        // raise both lines while scl low, then drop sda under high scl
                        // ph0 keeps scl as it is, so an idle bus never sees a stray clock
                        scl_reg <= ph_reg != 2'h0 || scl_reg;
                        sda_reg <= ph_reg < 2'h2;
                        if (ph_reg == 2'h3) begin
                            scl_reg <= 1'b0;
                            state_reg <= state_reg == twe_pkg::TWE_M_RSTART ?
                                twe_pkg::TWE_M_RSTOP : twe_pkg::TWE_M_IDLE;
                            done_reg <= state_reg != twe_pkg::TWE_M_RSTART;
                        end
                    end
                    twe_pkg::TWE_M_BIT, twe_pkg::TWE_M_RCLK: begin
                        // data moves only with scl low
                        if (ph_reg == 2'h0) begin
                            scl_reg <= 1'b0;
                        end else if (ph_reg == 2'h1) begin
                            sda_reg <= state_reg == twe_pkg::TWE_M_RCLK | sh_reg[8];
                        end else if (ph_reg == 2'h2) begin
                            scl_reg <= 1'b1;
                        end else begin
                            sh_reg <= {sh_reg[7:0], sda_sync_reg[1]};
                            cnt_reg <= cnt_reg + 4'h1;
                            if (cnt_reg == twe_pkg::RECOVERY_CLOCKS - 4'h1) begin
                                scl_reg <= 1'b0;
                                state_reg <= state_reg == twe_pkg::TWE_M_RCLK ?
                                    twe_pkg::TWE_M_RSTART : twe_pkg::TWE_M_IDLE;
                                done_reg <= state_reg == twe_pkg::TWE_M_BIT;
                                rd_data_reg <= sh_reg[7:0];
                                ack_reg <= !sda_sync_reg[1];
                            end
                        end
                    end
                    twe_pkg::TWE_M_STOP, twe_pkg::TWE_M_RSTOP: begin
                        // sda low under low scl, raise scl, then release sda
                        scl_reg <= ph_reg != 2'h0;
                        sda_reg <= ph_reg == 2'h3;
                        if (ph_reg == 2'h3) begin
                            state_reg <= twe_pkg::TWE_M_IDLE;
                            done_reg <= 1'b1;
                        end
                    end
                    default: state_reg <= twe_pkg::TWE_M_IDLE;
                endcase
            end
        end
    end

    assign link.scl_out = 1'b0;
    assign link.scl_oe_n = scl_reg;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe_n = sda_reg;
    assign busy = !idle;
    assign done = done_reg;
    assign rd_data = rd_data_reg;
    assign ack_seen = ack_reg;
endmodule

// *** verif/twe_link_monitor.sv ***
// checker: assertions on the shared clock and data wires
`timescale 1ns/1ps
module twe_link_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_d_oe_n
);
    // ------------------------------------------------
    // event decode at the core clock
    // ------------------------------------------------
    logic scl_reg, sda_reg, frame_reg, first_reg, rd_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    wire scl_rise = scl & ~scl_reg;
    wire scl_fall = ~scl & scl_reg;
    wire start_ev = scl & scl_reg & sda_reg & ~sda;
    wire stop_ev = scl & scl_reg & ~sda_reg & sda;
    wire ack_slot = scl_rise & (cnt_reg == 4'h8);
    // count wraps 9 to 1, so counts 8 and 9 span the whole ack slot
    wire [3:0] cnt_next = start_ev ? 4'h0 : ~scl_rise ? cnt_reg :
        (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
    wire [7:0] sh_next = (scl_rise & (cnt_reg < 4'h8)) ? {sh_reg[6:0], sda} : sh_reg;
    wire first_next = start_ev | (first_reg & ~ack_slot);
    wire rd_next = ~(start_ev | stop_ev) & (rd_reg | (ack_slot & first_reg & sh_reg[0] & ~sda));
    wire frame_next = start_ev | (frame_reg & ~stop_ev);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {scl_reg, sda_reg, frame_reg, first_reg, rd_reg} <= 5'h18;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
        end else begin
            {scl_reg, sda_reg, frame_reg, first_reg, rd_reg} <=
                {scl, sda, frame_next, first_next, rd_next};
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
        end
    end
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_dev_still_high;
        scl && scl_reg |-> $stable(sda_d_oe_n);
    endproperty
    a_dev_still_high: assert property (p_dev_still_high)
        else $error("device data enable moved with clock high");
    property p_dev_chg_low;
        $changed(sda_d_oe_n) |-> !scl;
    endproperty
    a_dev_chg_low: assert property (p_dev_chg_low)
        else $error("device data enable moved outside clock low");
    property p_start_hold;
        start_ev |-> (scl && !sda) [*8];
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("start condition not held");
    property p_stop_idle;
        stop_ev |-> (scl && sda) [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("bus not idle after stop");
    property p_idle_scl;
        !frame_reg |-> scl;
    endproperty
    a_idle_scl: assert property (p_idle_scl)
        else $error("clock low outside a frame");
    property p_dev_quiet;
        !sda_d_oe_n |-> (cnt_reg >= 4'h8) || rd_reg;
    endproperty
    a_dev_quiet: assert property (p_dev_quiet)
        else $error("device drives data outside ack or read slot");
    property p_no_ack_foreign;
        ack_slot && first_reg && sh_reg[7:4] != 4'hA |-> sda_d_oe_n;
    endproperty
    a_no_ack_foreign: assert property (p_no_ack_foreign)
        else $error("device acked a foreign address word");
    property p_ack_release;
        scl_fall && cnt_reg == 4'h9 && !rd_reg |-> ##[1:8] sda_d_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("device kept data low after ack slot");
    c_dev_ack: cover property (ack_slot && first_reg && !sda_d_oe_n);
    c_read: cover property (rd_reg && scl_rise && !sda_d_oe_n);
    c_stop: cover property (stop_ev);
endmodule

// *** verif/testbench.sv ***
// testbench: master and device ends joined over the two-wire link
`timescale 1ns/1ps
module testbench;
    // --------------------------------
    // stimulus and design ends
    // --------------------------------
    // write cycle shortened so the busy window is still longer than one poll
    localparam int WR_CYC = 4000;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_byte = 1'b0;
    logic cmd_stop = 1'b0;
    logic cmd_recover = 1'b0;
    logic cmd_read = 1'b0;
    logic cmd_ack = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic [2:0] hw_address_straps = 3'h0;
    logic tx_take, rx_valid, rx_is_addr, standby, busy, done, ack_seen;
    logic [7:0] rx_data, rd_data, aw;
    logic [2:0] me;
    logic [2:0] mq[$];
    logic [8:0] dq[$];
    logic [7:0] rq[$];
    int num_errors = 0;
    int total_checks = 0;
    always #20 core_clk = ~core_clk;
    twe_link_if i_twe_link_if ();
    twe_device #(.WRITE_CYCLES(WR_CYC)) i_twe_device (.core_clk(core_clk), .rstn(rstn),
        .link(i_twe_link_if.device), .hw_address_straps(hw_address_straps),
        .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_is_addr(rx_is_addr), .standby(standby));
    twe_master i_twe_master (.core_clk(core_clk), .rstn(rstn), .link(i_twe_link_if.master),
        .cmd_start(cmd_start), .cmd_byte(cmd_byte), .cmd_stop(cmd_stop),
        .cmd_recover(cmd_recover), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
        .cmd_data(cmd_data), .busy(busy), .done(done), .rd_data(rd_data), .ack_seen(ack_seen));
    twe_link_monitor i_twe_link_monitor (.core_clk(core_clk), .rstn(rstn),
        .scl(i_twe_link_if.scl), .sda(i_twe_link_if.sda),
        .sda_d_oe_n(i_twe_link_if.sda_d_oe_n));
    // --------------------------------
    // tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // k: 0 start, 1 byte, 2 stop, 3 recover; e: check data, check ack, ack value
    task automatic op(input int k, input logic [7:0] d, input logic rd, input logic ak,
        input logic [2:0] e);
        int n;
        mq.push_back(e);
        {cmd_start, cmd_byte, cmd_stop, cmd_recover} <= 4'h8 >> k;
        {cmd_data, cmd_read, cmd_ack} <= {d, rd, ak};
        @(posedge core_clk);
        {cmd_start, cmd_byte, cmd_stop, cmd_recover} <= 4'h0;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 3000) begin
            chk("done wait", 9'h001, 9'h000);
            finish_test();
        end
        chk("busy", 9'h000, {8'h00, busy});
    endtask
    task automatic bus(input int k);
        op(k, 8'h00, 1'b0, 1'b0, 3'h0);
    endtask
    task automatic wb(input logic [7:0] d, input logic a);
        dq.push_back({a, d});
        op(1, d, 1'b0, 1'b0, 3'h3);
    endtask
    // --------------------------------
    // read data source and result watcher
    // --------------------------------
    always @(posedge core_clk) begin
        if (tx_take === 1'b1) begin
            rq.push_back(tx_data);
            tx_data <= 8'($urandom);
        end
        if (done === 1'b1 && mq.size() > 0) begin
            me = mq.pop_front();
            if (me[1]) chk("ack_seen", {8'h00, me[0]}, {8'h00, ack_seen});
            if (me[2]) chk("rd_data", rq.size() > 0 ? {1'b0, rq.pop_front()} : 'x,
                {1'b0, rd_data});
        end
        if (rx_valid === 1'b1) chk("rx_word", dq.size() > 0 ? dq.pop_front() : 'x,
            {rx_is_addr, rx_data});
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        void'($urandom(32'h693C3DE6));
        hw_address_straps <= 3'($urandom);
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        aw = {4'hA, hw_address_straps[2], 2'($urandom), 1'b0};
        @(posedge core_clk);
        chk("standby", 9'h001, {8'h00, standby});
        bus(0);
        wb(aw, 1'b1);
        chk("standby", 9'h000, {8'h00, standby});
        for (int i = 0; i < 3; i++) begin
            wb(8'($urandom), 1'b0);
        end
        bus(2);
        // poll while the write cycle runs, then let it finish
        bus(0);
        op(1, aw, 1'b0, 1'b0, 3'h2);
        bus(2);
        repeat (WR_CYC) @(posedge core_clk);
        bus(0);
        wb(aw, 1'b1);
        wb(8'($urandom), 1'b0);
        bus(0);
        wb(aw | 8'h01, 1'b1);
        op(1, 8'h00, 1'b1, 1'b1, 3'h7);
        op(1, 8'h00, 1'b1, 1'b0, 3'h6);
        bus(2);
        repeat (WR_CYC) @(posedge core_clk);
        chk("standby", 9'h001, {8'h00, standby});
        for (int i = 0; i < 2; i++) begin
            bus(0);
            op(1, aw ^ (i ? 8'h08 : 8'hF0), 1'b0, 1'b0, 3'h2);
            bus(2);
        end
        bus(0);
        wb(aw, 1'b1);
        // the nine released clocks reach the device as an acked all-ones word
        dq.push_back(9'h0FF);
        bus(3);
        bus(0);
        wb(aw, 1'b1);
        bus(2);
        // reset in mid-frame
        bus(0);
        wb(aw, 1'b1);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("standby", 9'h001, {8'h00, standby});
        rq.delete();
        rstn <= 1'b1;
        @(posedge core_clk);
        bus(0);
        wb(aw, 1'b1);
        bus(2);
        chk("words left", 9'h000, 9'(dq.size()));
        finish_test();
    end
endmodule
